// ### bench/front_end_model.sv
`timescale 1ns/100ps
module front_end_model
(
	input  wire logic         mclk_i,
	input  wire logic [1:0]   take_i,
	output pairing_pkg::pair_t pair_o
);
	import pairing_pkg::*;
	instr_t prog [0:1] = '{INSTR_NONE, INSTR_NONE};
	int     ptr        = 2;
	initial pair_o = '0;
	// Past the program end the slot is invalid and shows no stale value.
	function automatic instr_t at(int k);
		instr_t v;
		v = ~prog[1];
		v.valid = 1'b0;
		return (k < 2) ? prog[k] : v;
	endfunction : at
	// The pair advances by the count taken, before the next decision edge.
	always @(negedge mclk_i)
	begin
		ptr = ptr + int'(take_i);
		pair_o = {at(ptr), at(ptr + 1)};
	end
endmodule : front_end_model

// ### bench/pairing_assertions.sv
`timescale 1ns/100ps
module pairing_checker
(
	input wire logic                mclk_i,
	input wire logic                rst_b_i,
	input wire pairing_pkg::pair_t  pair_i,
	input wire logic                exec_stall_i,
	input wire logic                elem_ptr_pending_i,
	input wire logic [1:0]          ldbuf_wait_i,
	input wire pairing_pkg::issue_t issue_o,
	input wire logic [1:0]          take_o,
	input wire logic                stall_o,
	input wire logic [15:0]         fused_total_o,
	input wire logic [15:0]         dual_total_o
);
	import pairing_pkg::*;
	logic      fu;
	logic      du;
	logic      is;
	op_class_t c0;
	op_class_t c1;
	assign fu = issue_o.kind == ISSUE_FUSED;
	assign du = issue_o.kind == ISSUE_DUAL;
	assign is = issue_o.kind != ISSUE_NONE;
	assign c0 = issue_o.slot0.cls;
	assign c1 = issue_o.slot1.cls;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	a_fuse_mov_first: assert property (fu |-> c0 == OP_MOV)
		else $error("fused without leading move");
	a_fuse_same_dst: assert property (fu |-> take_o == TAKE_TWO &&
		issue_o.slot0.dst == issue_o.slot1.dst && issue_o.slot1.dst != ZERO_REGISTER)
		else $error("bad fused destination");
	a_dual_later_kind: assert property (du |-> c1 inside {OP_UNCOND, OP_BCC, OP_SLD})
		else $error("dual with wrong later class");
	a_dual_aligned: assert property (du |-> !issue_o.slot0.unaligned_entry)
		else $error("dual after unaligned entry");
	a_sld_ptr_wait: assert property (du && c1 == OP_SLD |->
		!$past(elem_ptr_pending_i) && !issue_o.slot0.writes_elem_ptr)
		else $error("load paired over pointer write");
	a_sld_ldbuf_full: assert property (du && c1 == OP_SLD |->
		$past(ldbuf_wait_i) != LDBUF_ALL_WAIT)
		else $error("load paired with full buffers");
	a_bcc_leader: assert property (du && c1 == OP_BCC |->
		c0 inside {OP_NOP, OP_MOV, OP_MULH, OP_EXT, OP_SLD, OP_SST})
		else $error("branch paired with flag writer");
	a_sld_leader: assert property (du && c1 == OP_SLD |->
		!(c0 inside {OP_EXT, OP_SLD, OP_SST, OP_UNCOND, OP_BCC, OP_OTHER}))
		else $error("load paired with bad leader");
	a_uncond_leader: assert property (du && c1 == OP_UNCOND |->
		!(c0 inside {OP_EXT, OP_UNCOND, OP_BCC, OP_OTHER}))
		else $error("branch paired with bad leader");
	a_single_take: assert property (issue_o.kind == ISSUE_SINGLE |->
		take_o == TAKE_ONE && issue_o.slot1 == INSTR_NONE ##1 !is)
		else $error("single issue malformed");
	a_exec_hold: assert property (is |-> !$past(exec_stall_i))
		else $error("issue during execute stall");
	a_cmp_hazard: assert property (is && c0 == OP_CMP |=> ##1
		!(is && c0 == OP_BCC && issue_o.slot0.reads_flags))
		else $error("branch issued before compare done");
	a_stall_held: assert property (stall_o |-> $past(pair_i.first.valid) && !is)
		else $error("stall without held instruction");
	c_fused: cover property (fu);
	c_dual_load: cover property (du && c1 == OP_SLD);
	c_stall_then_issue: cover property (stall_o ##1 !stall_o ##[0:4] is);
endmodule : pairing_checker

bind dual_issue_pairing_control pairing_checker u_chk (.mclk_i, .rst_b_i, .pair_i,
	.exec_stall_i, .elem_ptr_pending_i, .ldbuf_wait_i, .issue_o, .take_o, .stall_o,
	.fused_total_o, .dual_total_o);

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
	import pairing_pkg::*;
	logic        mclk_i = 0, rst_b_i = 0, exec_stall_i = 0, elem_ptr_pending_i = 0;
	logic [1:0]  ldbuf_wait_i = '0, take_o;
	logic        stall_o;
	logic [15:0] ft, dt;
	pair_t       pair_i;
	issue_t      issue_o;
	issue_kind_t exp_q [$];
	issue_kind_t ek;
	logic [27:0] slot_q [$];
	logic [27:0] es;
	int          failures = 0, n_compared = 0, n_stall = 0, nf = 0, nd = 0;
	int          seed = 32'ha3aa6784;
	logic [4:0]  d;
	op_class_t   fz [5] = '{OP_SAT, OP_LOGIC, OP_ADDSUB, OP_SHIFT, OP_MULH};
	op_class_t   bl [12] = '{OP_NOP, OP_MOV, OP_NOT, OP_SAT, OP_LOGIC, OP_TST,
		OP_ADDSUB, OP_CMP, OP_SHIFT, OP_MULH, OP_SLD, OP_SST};
	op_class_t   cl [6] = '{OP_NOP, OP_MOV, OP_MULH, OP_EXT, OP_SLD, OP_SST};
	always #50 mclk_i = ~mclk_i;
	front_end_model fe (.mclk_i, .take_i(take_o), .pair_o(pair_i));
	dual_issue_pairing_control DUT (.mclk_i, .rst_b_i, .pair_i, .exec_stall_i,
		.elem_ptr_pending_i, .ldbuf_wait_i, .issue_o, .take_o, .stall_o,
		.fused_total_o(ft), .dual_total_o(dt));
	task automatic give_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_slots(logic [27:0] exp, logic [27:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED slots expected %h seen %h", exp, got);
		end
	endtask : chk_slots
	function automatic instr_t mk(op_class_t c, logic [4:0] r, logic [2:0] f);
		return {1'b1, c, 1'b1, r, f};
	endfunction : mk
	// e holds expected stall, execute stall, pointer pending, buffer waits.
	task automatic run(instr_t a, instr_t b, issue_kind_t k0, issue_kind_t k1,
		logic [4:0] e);
		int i;
		int s0;
		@(negedge mclk_i);
		{exec_stall_i, elem_ptr_pending_i, ldbuf_wait_i} = e[3:0];
		s0 = n_stall;
		exp_q.push_back(k0);
		slot_q.push_back({a, (k0 == ISSUE_SINGLE) ? INSTR_NONE : b});
		if (k1 != ISSUE_NONE)
		begin
			exp_q.push_back(k1);
			slot_q.push_back({b, INSTR_NONE});
		end
		nf += int'(k0 == ISSUE_FUSED);
		nd += int'(k0 == ISSUE_DUAL);
		@(posedge mclk_i);
		#1;
		fe.prog = '{a, b};
		fe.ptr = 0;
		repeat (3) @(negedge mclk_i);
		exec_stall_i = 1'b0;
		for (i = 0; i < 40 && exp_q.size() > 0; i++)
			@(negedge mclk_i);
		repeat (4) @(negedge mclk_i);
		chk("stall", 16'(e[4]), 16'(n_stall != s0));
		if (exp_q.size() > 0)
		begin
			failures++;
			give_verdict();
		end
		$display("test done kinds %0d %0d", k0, k1);
	endtask : run
	always @(negedge mclk_i)
	begin
		n_stall += int'(stall_o === 1'b1);
		if (issue_o.kind !== ISSUE_NONE)
		begin
			ek = exp_q.size() ? exp_q.pop_front() : ISSUE_NONE;
			chk("kind", 16'(ek), 16'(issue_o.kind));
			chk("take", (ek == ISSUE_SINGLE) ? 16'h1 : 16'h2, 16'(take_o));
			es = slot_q.size() ? slot_q.pop_front() : '0;
			chk_slots(es, {issue_o.slot0, issue_o.slot1});
		end
	end
	initial
	begin
		d = 5'($random(seed)) | 5'h01;
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_b_i = 1'b1;
		foreach (fz[i]) run(mk(OP_MOV, d, 0), mk(fz[i], d, 0), ISSUE_FUSED, ISSUE_NONE, 0);
		foreach (bl[i]) run(mk(bl[i], d, 0), mk(OP_UNCOND, 0, 0), ISSUE_DUAL, ISSUE_NONE, 0);
		foreach (cl[i]) run(mk(cl[i], d, 0), mk(OP_BCC, 0, 0), ISSUE_DUAL, ISSUE_NONE, 0);
		for (int i = 0; i < 10; i++)
			run(mk(bl[i], d, 0), mk(OP_SLD, 1, 0), ISSUE_DUAL, ISSUE_NONE, 0);
		run(mk(OP_ADDSUB, d, 0), mk(OP_MOV, d, 0), ISSUE_SINGLE, ISSUE_SINGLE, 0);
		run(mk(OP_MOV, 0, 0), mk(OP_ADDSUB, 0, 0), ISSUE_SINGLE, ISSUE_SINGLE, 0);
		run(mk(OP_EXT, d, 0), mk(OP_UNCOND, 0, 0), ISSUE_SINGLE, ISSUE_SINGLE, 0);
		run(mk(OP_ADDSUB, d, 0), mk(OP_BCC, 0, 0), ISSUE_SINGLE, ISSUE_SINGLE, 0);
		run(mk(OP_CMP, d, 0), mk(OP_BCC, 0, 2), ISSUE_SINGLE, ISSUE_SINGLE, 5'h10);
		run(mk(OP_ADDSUB, d, 0), mk(OP_SLD, 1, 0), ISSUE_SINGLE, ISSUE_SINGLE, 5'h04);
		run(mk(OP_MOV, d, 3'h4), mk(OP_SLD, 1, 0), ISSUE_SINGLE, ISSUE_SINGLE, 0);
		run(mk(OP_ADDSUB, d, 0), mk(OP_SLD, 1, 0), ISSUE_SINGLE, ISSUE_SINGLE, 5'h03);
		run(mk(OP_ADDSUB, d, 0), mk(OP_SLD, 1, 0), ISSUE_DUAL, ISSUE_NONE, 5'h01);
		run(mk(OP_MOV, d, 1), mk(OP_SLD, 1, 0), ISSUE_SINGLE, ISSUE_SINGLE, 0);
		run(mk(OP_NOP, d, 0), mk(OP_ADDSUB, d, 0), ISSUE_SINGLE, ISSUE_SINGLE, 0);
		run(mk(OP_MOV, d, 0), mk(OP_UNCOND, 0, 0), ISSUE_DUAL, ISSUE_NONE, 5'h18);
		chk("fused", 16'(nf), ft);
		chk("dual", 16'(nd), dt);
		give_verdict();
	end
endmodule : tb

// ### src/dual_issue_pairing_control.sv
`timescale 1ns/100ps
// Contract
// - Move then same-destination ALU op fuses into one operation, never for zero register.
// - Fusion happens only when the move is the earlier instruction.
// - Unconditional short branch dual-issues after listed ALU, move, nop or short memory ops.
// - Conditional branch dual-issues only after non-flag-updating listed instructions.
// - Short load dual-issues after nop, move, not, or listed ALU instructions.
// - Dual issue only when the later instruction is a branch or short load.
// - No pairing when the earlier instruction follows a branch to unaligned address.
// - No short load pairing while an element pointer write awaits writeback.
// - No conditional branch pairing when either of two prior instructions updates flags.
// - Conditional branch reading flags stalls until the compare executes, then issues singly.
// - No short load pairing while both load buffers await writeback.
module dual_issue_pairing_control
(
	input  wire logic              mclk_i,
	input  wire logic              rst_b_i,
	input  wire pairing_pkg::pair_t pair_i,
	input  wire logic              exec_stall_i,
	input  wire logic              elem_ptr_pending_i,
	input  wire logic [1:0]        ldbuf_wait_i,
	output pairing_pkg::issue_t    issue_o,
	output logic [1:0]             take_o,
	output logic                   stall_o,
	output logic [15:0]            fused_total_o,
	output logic [15:0]            dual_total_o
);
	import pairing_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Class helpers.

	// Second operations that may merge with a preceding register move.
	function automatic logic fuse_op(input op_class_t c);
		fuse_op = (c == OP_SAT) || (c == OP_LOGIC) || (c == OP_ADDSUB) ||
		          (c == OP_SHIFT) || (c == OP_MULH);
	endfunction : fuse_op

	// Leaders allowed in front of an unconditional short branch.
	function automatic logic uncond_lead(input op_class_t c);
		uncond_lead = (c == OP_NOP) || (c == OP_MOV) || (c == OP_NOT) || (c == OP_SLD) ||
		              (c == OP_SST) || (c == OP_SAT) || (c == OP_LOGIC) || (c == OP_TST) ||
		              (c == OP_ADDSUB) || (c == OP_CMP) || (c == OP_SHIFT) || (c == OP_MULH);
	endfunction : uncond_lead

	// Leaders in front of a conditional branch: none of them updates flags.
	function automatic logic bcc_lead(input op_class_t c);
		bcc_lead = (c == OP_NOP) || (c == OP_MOV) || (c == OP_MULH) || (c == OP_EXT) ||
		           (c == OP_SLD) || (c == OP_SST);
	endfunction : bcc_lead

	// Leaders in front of a short-displacement load.
	function automatic logic sld_lead(input op_class_t c);
		sld_lead = (c == OP_NOP) || (c == OP_MOV) || (c == OP_NOT) || (c == OP_SAT) ||
		           (c == OP_LOGIC) || (c == OP_TST) || (c == OP_ADDSUB) || (c == OP_CMP) ||
		           (c == OP_SHIFT) || (c == OP_MULH);
	endfunction : sld_lead

	// Classes that may change the flags; unknown classes count as writers.
	function automatic logic updates_flags(input instr_t i);
		updates_flags = i.valid &&
		                ((i.cls == OP_NOT) || (i.cls == OP_SAT) || (i.cls == OP_LOGIC) ||
		                 (i.cls == OP_TST) || (i.cls == OP_ADDSUB) || (i.cls == OP_CMP) ||
		                 (i.cls == OP_SHIFT) || (i.cls == OP_OTHER));
	endfunction : updates_flags

	////////////////////////////////////////////////////////////////////////////////
	// State.
	ctl_state_t    state_ff;
	ctl_state_t    nxt_state;
	issue_t        issue_ff;
	issue_t        nxt_issue;
	logic [1:0]    take_ff;
	logic [1:0]    nxt_take;
	logic          stall_ff;
	logic          nxt_stall;
	logic [1:0]    flag_busy_ff;
	logic [1:0]    nxt_flag_busy;
	logic          prev_flag_ff;
	logic          nxt_prev_flag;
	logic [15:0]   fused_total_ff;
	logic [15:0]   nxt_fused_total;
	logic [15:0]   dual_total_ff;
	logic [15:0]   nxt_dual_total;

	////////////////////////////////////////////////////////////////////////////////
	// Pairing qualification.
	instr_t        first;
	instr_t        second;
	logic          both_valid;
	logic          align_ok;
	logic          can_fuse;
	logic          uncond_ok;
	logic          bcc_ok;
	logic          sld_ok;
	logic          can_dual;
	logic          flag_stall;
	logic          issued_flags;

	always_comb
	begin
		first      = pair_i.first;
		second     = pair_i.second;
		both_valid = first.valid && second.valid;
		align_ok   = !first.unaligned_entry;

		can_fuse = both_valid && align_ok &&
		           (first.cls == OP_MOV) && first.reg_form &&
		           second.reg_form && fuse_op(second.cls) &&
		           (second.dst == first.dst) &&
		           (first.dst != ZERO_REGISTER);

		uncond_ok = (second.cls == OP_UNCOND) && uncond_lead(first.cls);

		bcc_ok = (second.cls == OP_BCC) && bcc_lead(first.cls) &&
		         !prev_flag_ff && (flag_busy_ff == 2'h0);

		sld_ok = (second.cls == OP_SLD) && sld_lead(first.cls) &&
		         !elem_ptr_pending_i && !first.writes_elem_ptr &&
		         (ldbuf_wait_i != LDBUF_ALL_WAIT);

		can_dual = both_valid && align_ok && (uncond_ok || bcc_ok || sld_ok);

		flag_stall = first.valid && (first.cls == OP_BCC) && first.reads_flags &&
		             ((flag_busy_ff != 2'h0) || prev_flag_ff);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Issue decision and sequencing.
	always_comb
	begin
		nxt_state       = state_ff;
		nxt_issue       = issue_ff;
		nxt_issue.kind  = ISSUE_NONE;
		nxt_take        = TAKE_NONE;
		nxt_stall       = 1'b0;
		nxt_fused_total = fused_total_ff;
		nxt_dual_total  = dual_total_ff;
		issued_flags    = 1'b0;
		unique case (state_ff)
			ST_DECIDE:
			begin
				if (first.valid && exec_stall_i)
				begin
					nxt_stall = 1'b1;
				end
				else if (flag_stall)
				begin
					nxt_stall = 1'b1;
				end
				else if (first.valid)
				begin
					nxt_state   = ST_SHIFT;
					nxt_issue.slot0 = first;
					if (can_fuse)
					begin
						nxt_issue.kind  = ISSUE_FUSED;
						nxt_issue.slot1 = second;
						nxt_take        = TAKE_TWO;
						nxt_fused_total = fused_total_ff + 16'h0001;
						issued_flags    = updates_flags(first) || updates_flags(second);
					end
					else if (can_dual)
					begin
						nxt_issue.kind  = ISSUE_DUAL;
						nxt_issue.slot1 = second;
						nxt_take        = TAKE_TWO;
						nxt_dual_total  = dual_total_ff + 16'h0001;
						issued_flags    = updates_flags(first) || updates_flags(second);
					end
					else
					begin
						nxt_issue.kind  = ISSUE_SINGLE;
						nxt_issue.slot1 = INSTR_NONE;
						nxt_take        = TAKE_ONE;
						issued_flags    = updates_flags(first);
					end
				end
			end
			ST_SHIFT:
			begin
				// The front end advances its pair during this cycle.
				nxt_state = ST_DECIDE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flag hazard tracking.
	always_comb
	begin
		nxt_flag_busy = flag_busy_ff;
		nxt_prev_flag = prev_flag_ff;
		if (issued_flags)
		begin
			nxt_flag_busy = FLAG_HAZARD_CYCLES;
		end
		else if (flag_busy_ff != 2'h0)
		begin
			nxt_flag_busy = flag_busy_ff - 2'h1;
		end
		if (nxt_issue.kind != ISSUE_NONE)
		begin
			nxt_prev_flag = issued_flags;
		end
		else if (flag_busy_ff == 2'h0)
		begin
			nxt_prev_flag = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_ff       <= ST_DECIDE;
			issue_ff       <= ISSUE_RESET;
			take_ff        <= TAKE_NONE;
			stall_ff       <= 1'b0;
			flag_busy_ff   <= 2'h0;
			prev_flag_ff   <= 1'b0;
			fused_total_ff <= TOTAL_RESET;
			dual_total_ff  <= TOTAL_RESET;
		end
		else
		begin
			state_ff       <= nxt_state;
			issue_ff       <= nxt_issue;
			take_ff        <= nxt_take;
			stall_ff       <= nxt_stall;
			flag_busy_ff   <= nxt_flag_busy;
			prev_flag_ff   <= nxt_prev_flag;
			fused_total_ff <= nxt_fused_total;
			dual_total_ff  <= nxt_dual_total;
		end
	end

	assign issue_o       = issue_ff;
	assign take_o        = take_ff;
	assign stall_o       = stall_ff;
	assign fused_total_o = fused_total_ff;
	assign dual_total_o  = dual_total_ff;

endmodule : dual_issue_pairing_control

// ### src/pairing_pkg.sv
package pairing_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction classes as seen by the issue-pairing logic.
	typedef enum logic [3:0]
	{
		OP_NOP    = 4'h0,
		OP_MOV    = 4'h1,
		OP_NOT    = 4'h2,
		OP_SAT    = 4'h3,
		OP_LOGIC  = 4'h4,
		OP_TST    = 4'h5,
		OP_ADDSUB = 4'h6,
		OP_CMP    = 4'h7,
		OP_SHIFT  = 4'h8,
		OP_MULH   = 4'h9,
		OP_EXT    = 4'ha,
		OP_SLD    = 4'hb,
		OP_SST    = 4'hc,
		OP_UNCOND = 4'hd,
		OP_BCC    = 4'he,
		OP_OTHER  = 4'hf
	} op_class_t;

	// One decoded candidate instruction.
	typedef struct packed
	{
		logic      valid;
		op_class_t cls;
		logic      reg_form;
		logic [4:0] dst;
		logic      writes_elem_ptr;
		logic      reads_flags;
		logic      unaligned_entry;
	} instr_t;

	// Two consecutive instructions in program order.
	typedef struct packed
	{
		instr_t first;
		instr_t second;
	} pair_t;

	typedef enum logic [1:0]
	{
		ISSUE_NONE   = 2'h0,
		ISSUE_SINGLE = 2'h1,
		ISSUE_DUAL   = 2'h2,
		ISSUE_FUSED  = 2'h3
	} issue_kind_t;

	typedef struct packed
	{
		issue_kind_t kind;
		instr_t      slot0;
		instr_t      slot1;
	} issue_t;

	typedef enum logic [1:0]
	{
		ST_DECIDE = 2'b00,
		ST_SHIFT  = 2'b01
	} ctl_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Constants.
	localparam logic [4:0]  ZERO_REGISTER      = 5'h00;
	localparam logic [1:0]  FLAG_HAZARD_CYCLES = 2'h2;
	localparam logic [1:0]  LDBUF_ALL_WAIT     = 2'h3;
	localparam logic [1:0]  TAKE_NONE          = 2'h0;
	localparam logic [1:0]  TAKE_ONE           = 2'h1;
	localparam logic [1:0]  TAKE_TWO           = 2'h2;
	localparam logic [15:0] TOTAL_RESET        = 16'h0000;
	localparam instr_t      INSTR_NONE         = '0;
	localparam issue_t      ISSUE_RESET        = '0;

endpackage : pairing_pkg
